/* rtl/idps_top.sv */
`timescale 1ns/1ps

// Functional notes
// - Watch hsync, vsync, green sync separately
// - Activity flags at 11h bits 7,6,5
// - Analog flag clears within 100 ms
// - Link clock detect stays on always; the code turns it off in power-down and while digital is picked
// - Link clock flag at 11h bit 4
// - Clock flag clears within 100 ms
// - After clock, count 32 consecutive DEs
// - Override zero auto, one uses choice
// - Override choice 0 analog, 1 digital
// - Nothing detected: both off, pin low
// - Only digital: digital on, analog off
// - Only analog: analog on, digital off
// - Both detected: choice sets priority
// - Digital active keeps band gap, hsync detect
// - Analog active keeps link clock detect
// - Power-down beats override beats auto
// - Register 12h bit 0 zero powers down
// - Analog detect is OR of bits 7..5
// - Seek state keeps detectors and band gap
module idps_top
    import idps_pkg::*;
#(
    parameter int LOSS_CYC = IDPS_LOSS_CYC
) (
    // Clock, reset, enable.
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Asynchronous sense inputs.
    input  wire logic       hsync_in,
    input  wire logic       vsync_in,
    input  wire logic       green_embedded_sync,
    input  wire logic       link_clk_seen,
    input  wire logic       de_in,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Power and status outputs.
    output idps_pwr_s       pwr_en,
    output logic            analog_active,
    output logic            digital_active,
    output logic            any_sync_found_pin
);

    // Data path overview. Five pin inputs are synchronised first. The four
    // sense inputs feed activity monitors whose flags are read back at the
    // status register. The link clock flag starts the second digital stage,
    // which counts data-enable pulses until a full run has been seen. The
    // selection logic then resolves power-down, override and automatic
    // detection, in that order, into at most one active interface. Every
    // result leaves the block through a flip-flop, and all state holds still
    // while clk_en is low.

    // Synchroniser stages and the delayed copy used for edge detection.
    logic [4:0]             sync1_q;
    logic [4:0]             sync2_q;
    logic [4:0]             prev_q;
    // Activity flags {link clock, green sync, vsync, hsync}.
    logic [3:0]             flag_q;
    // Control register: power, override enable and interface choice.
    logic [7:0]             ctrl_q;
    // Data-enable run counter, its gap timer and the detection stage.
    logic [5:0]             de_cnt_q;
    idps_dig_e              dig_q;
    logic [IDPS_TMR_W-1:0]  dg_tmr_q;
    // Decoded detection results and the chosen interface.
    logic                   analog_det;
    logic                   digital_det;
    logic                   pick_analog;
    logic                   pick_digital;
    logic                   pwr_on;
    logic                   ovr_on;
    logic                   choice_dig;
    logic                   dig_warm;

    // Two flip-flops on every pin input keep metastable levels away from the
    // logic; nothing but the second stage reads the first.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else if (clk_en) begin
            sync1_q <= {de_in, link_clk_seen, green_embedded_sync, vsync_in, hsync_in};
            sync2_q <= sync1_q;
        end
    end

    // Delayed copy of the synchronised levels, used only for edge detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prev_q <= 5'h00;
        end else if (clk_en) begin
            prev_q <= sync2_q;
        end
    end

    // One activity monitor per sense input; bit 3 watches the link clock level.
    // Each monitor owns one flag bit, so the flags are independent of each
    // other and a stopped input never holds up the others.
    for (genvar i = 0; i < 4; i++) begin : g_act
        idps_act_mon #(
            .LOSS_CYC (LOSS_CYC)
        ) i_mon (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .clk_en  (clk_en),
            .now_in  (sync2_q[i]),
            .was_in  (prev_q[i]),
            .active  (flag_q[i])
        );
    end

    // Digital detection in two stages. The clock stage only watches the link
    // clock flag, whose monitor is unpowered in digital mode and in absolute
    // power-down. The count stage needs 32 DE rising edges with no gap longer
    // than the loss window; losing the clock flag in any stage drops back to
    // the clock stage, so a stale count never completes a detection.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dig_q     <= DIG_IDLE;
            de_cnt_q  <= 6'h00;
            dg_tmr_q  <= '0;
        end else if (clk_en) begin
            case (dig_q)
                DIG_IDLE: begin
                    de_cnt_q <= 6'h00;
                    dg_tmr_q <= '0;
                    if (flag_q[IDPS_LCK_BIT - 1]) begin
                        dig_q <= DIG_COUNT;
                    end
                end
                DIG_COUNT: begin
                    if (!flag_q[IDPS_LCK_BIT - 1]) begin
                        dig_q <= DIG_IDLE;
                    end else if (sync2_q[4] && !prev_q[4]) begin
                        dg_tmr_q <= '0;
                        if (de_cnt_q == IDPS_DE_NEEDED - 6'h01) begin
                            dig_q <= DIG_FOUND;
                        end
                        de_cnt_q <= de_cnt_q + 6'h01;
                    end else if (dg_tmr_q >= IDPS_TMR_W'(LOSS_CYC - 1)) begin
                        de_cnt_q <= 6'h00; // Gap in DEs breaks the run.
                        dg_tmr_q <= '0;
                    end else begin
                        dg_tmr_q <= dg_tmr_q + 1'b1;
                    end
                end
                DIG_FOUND: begin
                    if (!flag_q[IDPS_LCK_BIT - 1]) begin
                        dig_q <= DIG_IDLE;
                    end
                end
                default: dig_q <= DIG_IDLE;
            endcase
        end
    end

    // Control register write; the power bit is active low, so writing it to 0
    // drops the block into absolute power-down.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_q <= IDPS_CONTROL_RST;
        end else if (clk_en && reg_wr && reg_addr == IDPS_CONTROL_ADDR) begin
            ctrl_q <= reg_wdata;
        end
    end

    // Register read of the flags and the control register. The flags live in
    // this clock domain already, so a read always sees one settled snapshot.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            case (reg_addr)
                IDPS_ACT_STATUS_ADDR:
                    reg_rdata <= {flag_q[0], flag_q[1], flag_q[2], flag_q[3], 4'h0};
                IDPS_CONTROL_ADDR:
                    reg_rdata <= ctrl_q;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // Detection results and control fields. The digital side only counts as
    // detected once the full DE run has been seen with the clock still present.
    always_comb begin
        analog_det  = flag_q[0] | flag_q[1] | flag_q[2];
        digital_det = flag_q[IDPS_LCK_BIT - 1] && (dig_q == DIG_FOUND);
        pwr_on      = ctrl_q[IDPS_PWR_BIT];
        ovr_on      = ctrl_q[IDPS_OVR_BIT];
        choice_dig  = ctrl_q[IDPS_CHOICE_BIT];
    end

    // Interface selection: power-down first, then override, then automatic
    // choice. Only one interface may win, so the two picks are exclusive.
    always_comb begin
        pick_analog  = 1'b0;
        pick_digital = 1'b0;
        if (!pwr_on) begin
            pick_analog  = 1'b0;
            pick_digital = 1'b0;
        end else if (ovr_on) begin
            pick_digital = choice_dig;
            pick_analog  = !choice_dig;
        end else if (analog_det && digital_det) begin
            pick_digital = choice_dig;
            pick_analog  = !choice_dig;
        end else begin
            pick_digital = digital_det;
            pick_analog  = analog_det;
        end
        dig_warm = pwr_on && (dig_q != DIG_IDLE) && !pick_analog && !ovr_on;
    end

    // Registered status outputs; the sync pin drops whenever no interface
    // is chosen, including absolute power-down.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            analog_active      <= 1'b0;
            digital_active     <= 1'b0;
            any_sync_found_pin <= 1'b0;
        end else if (clk_en) begin
            analog_active      <= pick_analog;
            digital_active     <= pick_digital;
            any_sync_found_pin <= pick_analog | pick_digital;
        end
    end

    // Power enables. Seek mode keeps only the detectors and the band gap; the
    // hsync detector joins them whenever either interface runs. The digital
    // core is also raised while the DE run is counted in automatic mode with analog not picked, since
    // the DEs can only be seen with it on.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pwr_en <= '0;
        end else if (clk_en) begin
            pwr_en.analog_core     <= pick_analog;
            pwr_en.digital_core    <= pick_digital | dig_warm;
            pwr_en.outputs         <= pick_analog | pick_digital;
            pwr_en.band_gap        <= pwr_on;
            pwr_en.hsync_detect    <= pick_analog | pick_digital;
            pwr_en.link_clk_detect <= pwr_on && !pick_digital;
            pwr_en.activity_detect <= pwr_on;
            pwr_en.green_sync      <= pwr_on;
        end
    end

endmodule : idps_top

// Activity monitor for one synchronised sense input. Any change of level
// marks the input active and restarts a quiet timer; once the timer has run
// for the whole loss window without a change the flag drops. The timer parks
// at the end of the window instead of wrapping, so a dead input never raises
// a false flag later, and an edge in the same cycle as the timeout wins.
module idps_act_mon
    import idps_pkg::*;
#(
    parameter int LOSS_CYC = IDPS_LOSS_CYC
) (
    // Clock, reset, enable.
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic clk_en,
    // Synchronised level and its copy from one cycle earlier.
    input  wire logic now_in,
    input  wire logic was_in,
    // Activity flag.
    output logic      active
);

    // Cycles since the last edge, held at the end of the window.
    logic [IDPS_TMR_W-1:0] quiet_q;

    // An edge sets the flag and clears the timer; a full quiet window clears the flag.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            active  <= 1'b0;
            quiet_q <= '0;
        end else if (clk_en) begin
            if (now_in != was_in) begin
                active  <= 1'b1;
                quiet_q <= '0;
            end else if (quiet_q >= IDPS_TMR_W'(LOSS_CYC - 1)) begin
                active  <= 1'b0;
            end else begin
                quiet_q <= quiet_q + 1'b1;
            end
        end
    end

endmodule : idps_act_mon

/* rtl/idps_pkg.sv */
package idps_pkg;

    // Register map of the control bus.
    localparam logic [7:0] IDPS_ACT_STATUS_ADDR = 8'h11;
    localparam logic [7:0] IDPS_CONTROL_ADDR    = 8'h12;
    localparam int         IDPS_HS_BIT          = 7;
    localparam int         IDPS_VS_BIT          = 6;
    localparam int         IDPS_GS_BIT          = 5;
    localparam int         IDPS_LCK_BIT         = 4;
    localparam int         IDPS_PWR_BIT         = 0;
    localparam int         IDPS_OVR_BIT         = 1;
    localparam int         IDPS_CHOICE_BIT      = 2;
    localparam logic [7:0] IDPS_CONTROL_RST     = 8'h01;

    // Timing: clock rate and loss timeout.
    localparam int         IDPS_CLK_HZ       = 10_000_000;
    localparam int         IDPS_LOSS_MS      = 100;
    localparam int         IDPS_LOSS_CYC     = IDPS_CLK_HZ / 1000 * IDPS_LOSS_MS;
    localparam int         IDPS_TMR_W        = 21;
    localparam logic [5:0] IDPS_DE_NEEDED    = 6'h20;

    // Digital detection stages.
    typedef enum logic [2:0] {
        DIG_IDLE  = 3'b001,
        DIG_COUNT = 3'b010,
        DIG_FOUND = 3'b100
    } idps_dig_e;

    // Power domain enables.
    typedef struct packed {
        logic analog_core;
        logic digital_core;
        logic outputs;
        logic band_gap;
        logic hsync_detect;
        logic link_clk_detect;
        logic activity_detect;
        logic green_sync;
    } idps_pwr_s;

endpackage : idps_pkg

/* sim/idps_top_chk.sv */
`timescale 1ns/1ps

// Port-level relations of the interface selector and its power enables.
module idps_top_chk
    import idps_pkg::*;
#(
    parameter int LOSS_CYC = 50
) (
    // Clock, reset and register requests.
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    // Design outputs.
    input wire logic [7:0] reg_rdata,
    input wire idps_pwr_s  pwr_en,
    input wire logic       analog_active,
    input wire logic       digital_active,
    input wire logic       any_sync_found_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    one_iface_a: assert property (!(analog_active && digital_active))
        else $error("both interfaces active");
    dig_keeps_a: assert property (digital_active |-> pwr_en.band_gap && pwr_en.hsync_detect)
        else $error("digital mode lost band gap or hsync detect");
    ana_keeps_a: assert property (analog_active |-> pwr_en.link_clk_detect)
        else $error("analog mode lost link clock detect");
    idle_pin_a: assert property (!analog_active && !digital_active |-> !any_sync_found_pin)
        else $error("sync pin high with no interface");
    ana_off_a: assert property (digital_active |-> !pwr_en.analog_core && pwr_en.digital_core)
        else $error("digital mode power enables wrong");
    dig_off_a: assert property (analog_active |-> !pwr_en.digital_core && pwr_en.analog_core)
        else $error("analog mode power enables wrong");
    status_low_a: assert property (reg_rd && clk_en && reg_addr == IDPS_ACT_STATUS_ADDR
        |=> reg_rdata[3:0] == 4'h0)
        else $error("status low bits not zero");
    rd_hold_a: assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule : idps_top_chk

/* sim/idps_video_src.sv */
`timescale 1ns/1ps

// Video source: syncs, link clock and data enable run only while requested.
module idps_video_src (
    // Clock and run requests {de, link clock, green, vsync, hsync}.
    input  wire logic       clk_sys,
    input  wire logic [4:0] run,
    // Source lines.
    output logic      [4:0] lines
);
    logic [1:0] ph_q = 2'h0;
    // A stopped source stands still at low; the link clock toggles each cycle.
    always @(posedge clk_sys) begin
        ph_q       <= ph_q + 2'h1;
        lines[2:0] <= run[2:0] & {3{ph_q[1]}};
        lines[3]   <= run[3] & ~lines[3];
        lines[4]   <= run[4] & ph_q[1];
    end
endmodule : idps_video_src

/* sim/idps_top_bench.sv */
`timescale 1ns/1ps

// Walks the selector through detection, choice, override and power-down.
module idps_top_bench
    import idps_pkg::*;
;
    logic       clk_sys, rst_b, clk_en, reg_wr, reg_rd, ana, dig, pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] run, lines;
    idps_pwr_s  pwr_en;
    int         err_count = 0;
    int         tests_run = 0;
    idps_top #(.LOSS_CYC(50)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .hsync_in(lines[0]), .vsync_in(lines[1]), .green_embedded_sync(lines[2]),
        .link_clk_seen(lines[3]), .de_in(lines[4]), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwr_en(pwr_en),
        .analog_active(ana), .digital_active(dig), .any_sync_found_pin(pin));
    idps_video_src i_src (.clk_sys(clk_sys), .run(run), .lines(lines));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk("rdata", e, reg_rdata);
    endtask : rd
    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= IDPS_CONTROL_ADDR;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic go(input logic [4:0] r, input int n);
        @(posedge clk_sys);
        run <= r;
        repeat (n) @(posedge clk_sys);
    endtask : go
    task automatic act(input string n, input logic [1:0] e);
        @(negedge clk_sys);
        chk(n, {6'h0, e}, {6'h0, ana, dig});
    endtask : act
    task automatic des(input int n);
        go(5'h18, 0);
        repeat (n) @(posedge lines[4]);
        go(5'h08, 10);
    endtask : des
    task automatic report_and_stop;
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Free-running system clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog well beyond the fewer than one thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, run} = '0;
        clk_en = 1'b1;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(IDPS_CONTROL_ADDR, IDPS_CONTROL_RST);
        rd(8'h30, 8'h00);
        go(5'h00, 10);
        @(negedge clk_sys);
        chk("seek power", 8'h17, pwr_en);
        chk("sync pin", 8'h00, {7'h0, pin});
        for (int i = 0; i < 3; i++) begin
            go(5'h01 << i, 60);
            rd(IDPS_ACT_STATUS_ADDR, 8'h80 >> i);
            act("analog only", 2'b10);
        end
        go(5'h00, 80);
        rd(IDPS_ACT_STATUS_ADDR, 8'h00);
        act("none", 2'b00);
        go(5'h08, 20);
        rd(IDPS_ACT_STATUS_ADDR, 8'h10);
        des(31);
        act("31 de", 2'b00);
        des(1);
        act("digital only", 2'b01);
        go(5'h00, 80);
        rd(IDPS_ACT_STATUS_ADDR, 8'h00);
        act("clock lost", 2'b00);
        go(5'h19, 200);
        act("both choice 0", 2'b10);
        wr(8'h05);
        go(5'h19, 5);
        act("both choice 1", 2'b01);
        wr(8'h03);
        go(5'h19, 5);
        act("force analog", 2'b10);
        wr(8'h07);
        go(5'h00, 100);
        act("force digital", 2'b01);
        wr(8'h06);
        go(5'h00, 5);
        act("power down", 2'b00);
        chk("off power", 8'h00, pwr_en);
        report_and_stop();
    end
endmodule : idps_top_bench

bind idps_top idps_top_chk #(.LOSS_CYC(LOSS_CYC)) i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwr_en(pwr_en), .analog_active(analog_active), .digital_active(digital_active),
    .any_sync_found_pin(any_sync_found_pin));
